// >>> design/flash_status_pkg.sv
// Purpose: shared constants for the flash status polling controller
// Assumes: 125 MHz clock, 32-bit APB register access
// Notes:   register word offsets are byte addresses
package flash_status_pkg;
  localparam int          CLK_MHZ          = 125;
  localparam int          ADDR_W           = 20;
  localparam int          DATA_W           = 8;
  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET      = 12'h000;
  localparam logic [11:0] ADDR_OFFSET      = 12'h004;
  localparam logic [11:0] STATUS_OFFSET    = 12'h008;
  localparam logic [11:0] RESULT_OFFSET    = 12'h00C;
  // control fields
  localparam int          CTRL_START_BIT   = 0;
  localparam int          CTRL_ERASE_BIT   = 1;
  localparam int          CTRL_EXPECT_LSB  = 8;
  // status fields
  localparam int          ST_BUSY_BIT      = 0;
  localparam int          ST_DONE_BIT      = 1;
  localparam int          ST_FAIL_BIT      = 2;
  localparam int          ST_SUSP_BIT      = 3;
  localparam int          ST_WINDOW_BIT    = 4;
  localparam int          ST_PIN_BUSY_BIT  = 5;
  // data bus bit positions
  localparam int          POLL_POS         = 7;
  localparam int          MODE_TOG_POS     = 6;
  localparam int          LIMIT_POS        = 5;
  localparam int          WINDOW_POS       = 3;
  localparam int          SECT_TOG_POS     = 2;
  // read cycle timing
  localparam int          READ_NS          = 80;
  localparam int          READ_CYCLES      = (READ_NS * CLK_MHZ + 999) / 1000;
  localparam int          GAP_NS           = 16;
  localparam int          GAP_CYCLES       = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  TIMER_W1         = 8'h01;
  typedef enum logic [2:0] {IDLE, SETUP, STROBE, GAP, EVAL, FINISH} poll_state_type;
endpackage : flash_status_pkg

// >>> design/flash_status_poller.sv
// Purpose: host-side controller that polls write-operation status of a parallel NOR flash
// Assumes: flash output enable and chip enable driven low-active; data pins sampled via two flops
// Notes:   software starts a poll over APB; result is taken from two back-to-back toggle reads
// What the datasheet requires of the flash and its host
// R01 - during program, poll bit reads complement; afterwards the true written bit
// R02 - same complement-then-true polling applies to program during erase suspend
// R03 - status valid from last write-enable rising edge; polling starts after that
// R04 - host puts the programmed address on the bus while reading status
// R05 - protected-sector program shows polling about one microsecond, then array data
// R06 - erase reads poll bit 0; complete or suspended reads 1
// R07 - during erase host reads at an address inside a selected sector
// R08 - all-protected erase shows polling about 100 us, then array data
// R09 - partly protected erase erases only unprotected selected sectors
// R10 - after poll bit turns true, valid byte taken on a later read
// R11 - ready/busy is open drain, wired among devices with pull-up
// R12 - ready/busy low while erasing or programming, high when ready
// R13 - mode toggle bit changes on each read during operation, stops after
// R14 - toggle reads may be framed by output enable or chip enable
// R15 - mode toggle bit also valid during sector-erase acceptance window
// R16 - mode toggle toggles during erase, stops in erase suspend
// R17 - mode toggle toggles during suspend-program, stops when it completes
// R18 - sector toggle bit toggles on reads in selected sectors, erasing or suspended
// R19 - host combines sector toggle and mode toggle for sector and mode
// R20 - limit exceeded bit 1 means failure; host must issue reset command (this block only sets fail, it sends no command)
// R21 - erase window bit 0 while more erase commands accepted, 1 once erasing
// R22 - toggling bit inverts each completed read, consecutive reads differ
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module flash_status_poller
  import flash_status_pkg::*;
#(
  parameter int ADDR_WIDTH = flash_status_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [11:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // flash bus
  output logic      [ADDR_WIDTH-1:0]         flash_addr,
  output logic                               flash_ce_n,
  output logic                               flash_oe_n,
  input  wire logic [flash_status_pkg::DATA_W-1:0] flash_data,
  input  wire logic                          ready_busy_n
);
  import flash_status_pkg::*;

  // elaboration check: the target address must fit one apb word
  if (ADDR_WIDTH < 1 || ADDR_WIDTH > 32) begin : gen_bad_width
    $error("ADDR_WIDTH out of range");
  end

  // reset synchroniser
  logic rst_meta;
  logic rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_b <= rst_meta;
    end
  end

  // data and ready pins pass two flops; only the second stage is read
  logic [DATA_W-1:0] data_meta;
  logic [DATA_W-1:0] data_sync;
  logic              rb_meta;
  logic              rb_sync_n;
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      data_meta <= '0;
      data_sync <= '0;
      rb_meta   <= 1'b1;
      rb_sync_n <= 1'b1;
    end else begin
      data_meta <= flash_data;
      data_sync <= data_meta;
      rb_meta   <= ready_busy_n;
      rb_sync_n <= rb_meta;
    end
  end

  // control state
  poll_state_type           state;
  poll_state_type           next_state;
  logic [ADDR_WIDTH-1:0]    target;
  logic [ADDR_WIDTH-1:0]    next_target;
  logic                     is_erase;
  logic                     next_is_erase;
  logic                     expect_bit;
  logic                     next_expect_bit;
  logic [7:0]               timer;
  logic [7:0]               next_timer;
  logic                     have_first;
  logic                     next_have_first;
  logic [DATA_W-1:0]        first_read;
  logic [DATA_W-1:0]        next_first_read;
  logic [DATA_W-1:0]        last_read;
  logic [DATA_W-1:0]        next_last_read;
  logic                     done;
  logic                     next_done;
  logic                     fail;
  logic                     next_fail;
  logic                     susp;
  logic                     next_susp;
  logic                     window;
  logic                     next_window;
  logic                     use_ce;
  logic                     next_use_ce;
  logic                     seen_fail;
  logic                     next_seen_fail;

  logic wr_ctrl;
  logic wr_addr;
  assign wr_ctrl = psel && penable && pwrite && paddr == CTRL_OFFSET;
  assign wr_addr = psel && penable && pwrite && paddr == ADDR_OFFSET;

  function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b, input int pos);
    toggled = a[pos] ^ b[pos];
  endfunction : toggled

  // next-state of the polling sequencer
  always_comb begin
    next_state      = state;
    next_target     = target;
    next_is_erase   = is_erase;
    next_expect_bit = expect_bit;
    next_timer      = timer;
    next_have_first = have_first;
    next_first_read = first_read;
    next_last_read  = last_read;
    next_done       = done;
    next_fail       = fail;
    next_susp       = susp;
    next_window     = window;
    next_use_ce     = use_ce;
    next_seen_fail  = seen_fail;
    if (wr_addr && state == IDLE) begin
      next_target = pwdata[ADDR_WIDTH-1:0];
    end
    case (state)
      IDLE: begin
        // R03 start after write
        if (wr_ctrl && pwdata[CTRL_START_BIT]) begin
          next_is_erase   = pwdata[CTRL_ERASE_BIT];
          next_expect_bit = pwdata[CTRL_EXPECT_LSB + POLL_POS];
          next_have_first = 1'b0;
          next_done       = 1'b0;
          next_fail       = 1'b0;
          next_seen_fail  = 1'b0;
          next_state      = SETUP;
        end
      end
      SETUP: begin
        next_timer = 8'(READ_CYCLES);
        next_state = STROBE;
      end
      STROBE: begin
        if (timer == TIMER_W1) begin
          // capture while the strobe still stands; the released bus is not data
          next_last_read = data_sync;
          next_timer     = 8'(GAP_CYCLES + 2);
          next_state     = GAP;
        end else begin
          next_timer = timer - TIMER_W1;
        end
      end
      GAP: begin
        // recovery time so the flash lets go of the bus before the next read
        if (timer == TIMER_W1) begin
          next_state = EVAL;
        end else begin
          next_timer = timer - TIMER_W1;
        end
      end
      EVAL: begin
        // R14 alternate framing
        next_use_ce = !use_ce;
        if (!have_first) begin
          next_have_first = 1'b1;
          next_first_read = last_read;
          next_state      = SETUP;
        // R22 two reads compared
        end else if (!toggled(first_read, last_read, MODE_TOG_POS)) begin
          // R13 toggle stopped
          // R16 suspend detect
          // R19 combine both toggles
          next_susp   = is_erase && toggled(first_read, last_read, SECT_TOG_POS);
          // R21 window bit
          next_window = last_read[WINDOW_POS];
          // R01 true data check
          // R06 erase reads one
          // R10 later read used
          next_fail   = is_erase ? !last_read[POLL_POS] : (last_read[POLL_POS] != expect_bit);
          next_done   = 1'b1;
          next_state  = FINISH;
        // R20 limit recheck
        end else if (last_read[LIMIT_POS] && seen_fail) begin
          next_fail  = 1'b1;
          next_done  = 1'b1;
          next_state = FINISH;
        end else begin
          next_seen_fail  = last_read[LIMIT_POS];
          next_window     = last_read[WINDOW_POS];
          next_first_read = last_read;
          next_state      = SETUP;
        end
      end
      FINISH: begin
        next_state = IDLE;
      end
      default: begin
        next_state = IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state      <= IDLE;
      target     <= '0;
      is_erase   <= 1'b0;
      expect_bit <= 1'b0;
      timer      <= 8'h00;
      have_first <= 1'b0;
      first_read <= '0;
      last_read  <= '0;
      done       <= 1'b0;
      fail       <= 1'b0;
      susp       <= 1'b0;
      window     <= 1'b0;
      use_ce     <= 1'b0;
      seen_fail  <= 1'b0;
    end else begin
      state      <= next_state;
      target     <= next_target;
      is_erase   <= next_is_erase;
      expect_bit <= next_expect_bit;
      timer      <= next_timer;
      have_first <= next_have_first;
      first_read <= next_first_read;
      last_read  <= next_last_read;
      done       <= next_done;
      fail       <= next_fail;
      susp       <= next_susp;
      window     <= next_window;
      use_ce     <= next_use_ce;
      seen_fail  <= next_seen_fail;
    end
  end

  // flash strobes from flops; ce frames each read when use_ce, else held low
  logic next_ce_n;
  logic next_oe_n;
  logic [ADDR_WIDTH-1:0] next_faddr;
  always_comb begin
    next_faddr = flash_addr;
    next_ce_n  = 1'b1;
    next_oe_n  = 1'b1;
    if (next_state == SETUP || next_state == STROBE || next_state == GAP || next_state == EVAL) begin
      // R04 programmed address
      // R07 selected sector address
      next_faddr = next_target;
      next_ce_n  = use_ce ? (next_state != STROBE) : 1'b0;
      next_oe_n  = use_ce ? 1'b0 : (next_state != STROBE);
    end
  end
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      flash_addr <= '0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end else begin
      flash_addr <= next_faddr;
      flash_ce_n <= next_ce_n;
      flash_oe_n <= next_oe_n;
    end
  end

  // apb read mux, zero wait states
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      CTRL_OFFSET:   next_prdata = {31'h0000_0000, is_erase} << CTRL_ERASE_BIT;
      ADDR_OFFSET:   next_prdata = 32'(target);
      STATUS_OFFSET: begin
        next_prdata[ST_BUSY_BIT]     = state != IDLE;
        next_prdata[ST_DONE_BIT]     = done;
        next_prdata[ST_FAIL_BIT]     = fail;
        next_prdata[ST_SUSP_BIT]     = susp;
        next_prdata[ST_WINDOW_BIT]   = window;
        // R12 busy pin seen
        next_prdata[ST_PIN_BUSY_BIT] = !rb_sync_n;
      end
      RESULT_OFFSET: next_prdata = {16'h0000, first_read, last_read};
      default:       next_prdata = 32'h0000_0000;
    endcase
  end
  assign prdata  = next_prdata;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !(paddr == CTRL_OFFSET || paddr == ADDR_OFFSET ||
                                        paddr == STATUS_OFFSET || paddr == RESULT_OFFSET);
endmodule : flash_status_poller
`default_nettype wire

// >>> tb/flash_status_poller_checker.sv
// Purpose: port checks on the status poller
// Assumes: one clock, reset active low
// Notes:   bound from the bench top
`timescale 1ns/10ps
`default_nettype none
module flash_status_poller_checker
  import flash_status_pkg::*;
#(
  parameter int ADDR_WIDTH = 20
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst_b,
  // apb
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // flash bus
  input wire logic [ADDR_WIDTH-1:0] flash_addr,
  input wire logic                  flash_ce_n,
  input wire logic                  flash_oe_n,
  input wire logic                  ready_busy_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // read strobe and register decode
  wire logic strobe = !flash_ce_n && !flash_oe_n;
  wire logic acc    = psel && penable;
  wire logic mapped = paddr inside {CTRL_OFFSET, ADDR_OFFSET, STATUS_OFFSET, RESULT_OFFSET};
  sequence strobe_ten;
    strobe [*8] ##1 strobe ##1 strobe;
  endsequence
  // pin unchanged for four samples, sync flops have caught up
  sequence pin_settled;
    $stable(ready_busy_n) && $past(ready_busy_n, 2) == ready_busy_n && $past(ready_busy_n, 3) == ready_busy_n;
  endsequence
  chk_zero_wait: assert property (acc |-> pready)
    else $error("apb access not answered at once");
  chk_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without error");
  chk_unmapped_zero: assert property (acc && !mapped && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
    else $error("mapped access flagged error");
  chk_addr_steady: assert property (strobe |-> $stable(flash_addr))
    else $error("flash address moved during read");
  chk_strobe_len: assert property ($rose(strobe) |-> strobe_ten ##1 !strobe)
    else $error("read strobe not ten cycles");
  chk_one_framing: assert property ($rose(strobe) |-> $fell(flash_ce_n) != $fell(flash_oe_n))
    else $error("read not framed by exactly one enable");
  chk_read_gap: assert property ($fell(strobe) |-> !strobe [*4])
    else $error("read gap too short");
  chk_pin_status: assert property (pin_settled ##0 (acc && !pwrite && paddr == STATUS_OFFSET)
    |-> prdata[ST_PIN_BUSY_BIT] == !ready_busy_n) else $error("pin busy bit wrong");
endmodule : flash_status_poller_checker
`default_nettype wire

// >>> tb/flash_device_model.sv
// Purpose: behavioural flash answering status reads
// Assumes: a read ends when ce or oe rises
// Notes:   op picks the running algorithm
`timescale 1ns/10ps
`default_nettype none
module flash_device_model #(
  parameter int          RUN_READS = 6,
  parameter logic [19:0] TARGET    = 20'h32A54
) (
  // host bus
  input  wire logic [19:0] flash_addr,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  output logic      [7:0]  flash_data,
  output logic             rb_oe_n,
  // 1 program 2 erase 3 suspended 4 suspend program 5 over limit
  input  wire logic [2:0]  op,
  input  wire logic [7:0]  pbyte
);
  logic       tog  = 1'h0;
  int         reads = 0;
  logic [7:0] last = 8'h00;
  logic [7:0] status;
  wire logic  reading = !flash_ce_n && !flash_oe_n;
  wire logic  busy = (op == 3'h5) || (op inside {3'h1, 3'h2, 3'h4} && reads < RUN_READS);
  assign rb_oe_n = !busy;
  logic [2:0] op_seen = 3'h0;
  logic       was_reading = 1'h0;
  // one process owns the counters: a new operation restarts the algorithm
  // each finished read toggles
  always @(op or reading) begin
    if (op != op_seen) begin
      op_seen = op;
      tog     = 1'h0;
      reads   = 0;
    end else if (was_reading && !reading) begin
      last  = status;
      tog   = ~tog;
      reads = reads + 1;
    end
    was_reading = reading;
  end
  always @* begin
    case (op)
      3'h1, 3'h4: status = {~pbyte[7], tog, 6'h00};
      3'h2: status = {1'h0, tog, 2'h0, reads > 1, tog, 2'h0};
      3'h3: status = {1'h1, 4'h0, tog, 2'h0};
      3'h5: status = {~pbyte[7], tog, 1'h1, 5'h00};
      default: status = pbyte;
    endcase
    // done or off target gives array
    if ((!busy && op != 3'h3) || flash_addr != TARGET) status = (op == 3'h2) ? 8'hFF : pbyte;
  end
  // released bus must not hold the last byte
  assign flash_data = reading ? status : ~last;
endmodule : flash_device_model
`default_nettype wire

// >>> tb/test_flash_status_poller.sv
// Purpose: self-checking bench for the status poller
// Assumes: device model answers status reads
// Notes:   one table row per case; program has two rows, right and wrong poll
`timescale 1ns/10ps
`default_nettype none
module test_flash_status_poller;
  import flash_status_pkg::*;
  typedef struct packed {
    logic [2:0] op;
    logic [7:0] data;
    logic [7:0] want;
    logic       erase;
    logic [4:0] smask;
    logic [4:0] sexp;
    logic [8:0] res;
  } case_type;
  // program, suspend program, erase, wrong poll, over limit, suspended
  localparam case_type TAB [6] = '{'{3'h1, 8'hA5, 8'hA5, 1'h0, 5'h07, 5'h02, 9'h1A5},
    '{3'h4, 8'h3C, 8'h3C, 1'h0, 5'h07, 5'h02, 9'h13C}, '{3'h2, 8'h00, 8'hFF, 1'h1, 5'h17, 5'h12, 9'h1FF},
    '{3'h1, 8'hA5, 8'h25, 1'h0, 5'h05, 5'h04, 9'h000}, '{3'h5, 8'hA5, 8'hA5, 1'h0, 5'h05, 5'h04, 9'h000},
    '{3'h3, 8'h00, 8'hFF, 1'h1, 5'h09, 5'h08, 9'h000}};
  logic        clk = 1'h0;
  logic        rst_b = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic [19:0] flash_addr;
  logic        flash_ce_n;
  logic        flash_oe_n;
  logic [7:0]  flash_data;
  logic        rb_oe_n;
  logic [2:0]  op = 3'h0;
  logic [7:0]  pbyte = 8'h00;
  int          failures = 0;
  int          checked = 0;
  int          cycles = 0;
  // pull-up on the shared busy line
  wire logic   ready_busy_n = rb_oe_n ? 1'h1 : 1'h0;
  always #4 clk = ~clk;
  flash_status_poller dut_u (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
    .flash_data(flash_data), .ready_busy_n(ready_busy_n));
  flash_device_model model_u (.flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_data(flash_data), .rb_oe_n(rb_oe_n), .op(op), .pbyte(pbyte));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    // sample at the rising edge that sees pready; request held until then
    do @(posedge clk); while (pready !== 1'h1);
    rd = prdata;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic results;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    apb(1'h0, STATUS_OFFSET, 32'h0000_0000);
    check("reset status", rd, 32'h0000_0000);
    apb(1'h0, 12'h010, 32'h0000_0000);
    check("unmapped read", rd, 32'h0000_0000);
    apb(1'h1, ADDR_OFFSET, 32'h0003_2A54);
    apb(1'h0, ADDR_OFFSET, 32'h0000_0000);
    check("target address", rd, 32'h0003_2A54);
    foreach (TAB[i]) begin
      op    <= TAB[i].op;
      pbyte <= TAB[i].data;
      @(posedge clk);
      apb(1'h1, CTRL_OFFSET, {16'h0000, TAB[i].want, 6'h00, TAB[i].erase, 1'h1});
      apb(1'h0, STATUS_OFFSET, 32'h0000_0000);
      check("pin busy", 32'(rd[ST_PIN_BUSY_BIT]), 32'(TAB[i].op != 3'h3));
      // poll until the controller is idle; the timeout bounds it
      do apb(1'h0, STATUS_OFFSET, 32'h0000_0000); while (rd[ST_BUSY_BIT] !== 1'h0);
      check("final status", 32'(rd[4:0] & TAB[i].smask), 32'(TAB[i].sexp));
      if (TAB[i].res[8]) begin
        apb(1'h0, RESULT_OFFSET, 32'h0000_0000);
        check("array byte", 32'(rd[7:0]), 32'(TAB[i].res[7:0]));
      end
      $display("test %0d over", i);
    end
    results();
  end
endmodule : test_flash_status_poller
bind flash_status_poller flash_status_poller_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk_u (.clk(clk),
  .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .ready_busy_n(ready_busy_n));
`default_nettype wire
